// file: rtl/tir_consts.svh
// Offsets, field positions, reset values and timing counts of the transceiver/interrupt register bank.
// Assumes inclusion by bare name from rtl/.
`ifndef TIR_CONSTS_SVH
`define TIR_CONSTS_SVH
// Register offsets (main bank 0x0x, alternate bank 0x1x)
`define TIR_OFF_NCF_STATUS 5'h01
`define TIR_OFF_INT_CONTROL 5'h02
`define TIR_OFF_TIMER_HIGH 5'h1d
`define TIR_OFF_STACK_PTRS 5'h1e
`define TIR_OFF_INT_BASE 5'h11
`define TIR_OFF_RX_TX_PORT 5'h14
`define TIR_OFF_XCVR_CMD 5'h16
`define TIR_OFF_XCVR_MODE 5'h17
`define TIR_OFF_LINK_CTRL 5'h18
`define TIR_OFF_VECTOR 5'h19
// Vector source addresses
`define TIR_VEC_NMI 6'h1c
`define TIR_VEC_RX 6'h04
`define TIR_VEC_TX 6'h08
`define TIR_VEC_LTA 6'h0c
`define TIR_VEC_BIDIR 6'h10
`define TIR_VEC_TIMER 6'h14
// Receiver interrupt source codes
`define TIR_RIS_FULL 2'h0
`define TIR_RIS_DAV 2'h1
`define TIR_RIS_ACTIVE 2'h3
// Field positions
`define TIR_MODE_SRST 7
`define TIR_MODE_LOOP 6
`define TIR_MODE_REPEAT_ENABLE 5
`define TIR_MODE_RINV 4
`define TIR_MODE_TINV 3
`define TIR_CMD_RLQ 7
`define TIR_CMD_SEC 6
`define TIR_CMD_SLR 5
`define TIR_CMD_ATA 4
`define TIR_CMD_OWP 3
`define TIR_LINK_BIDIR_OUT 0
`define TIR_LINK_EOM 1
// Reset values
`define TIR_RST_ICR 8'hdf
`define TIR_RST_ZERO 8'h00
// Quiet periods before line_active drops
`define TIR_LA_QUIET 5'd16
// Receive FIFO fill level that sets rx_fifo_full
`define TIR_RX_FULL_LEVEL 2'd3
`endif

// file: rtl/tir_pkg.sv
// Types shared by the transceiver/interrupt register bank.
// Assumes tir_consts.svh holds the numbers.
`default_nettype none
package tir_pkg;
  typedef enum logic [2:0] {
    TIR_PROTO_COAX = 3'h0,
    TIR_PROTO_MUX = 3'h1,
    TIR_PROTO_CTRL = 3'h2,
    TIR_PROTO_RPT = 3'h3,
    TIR_PROTO_TWINAX = 3'h4,
    TIR_PROTO_TWINAX_PROM = 3'h5,
    TIR_PROTO_BYTE = 3'h6,
    TIR_PROTO_BYTE_PROM = 3'h7
  } tir_proto_t;
  typedef enum logic [2:0] {
    TIR_TX_IDLE = 3'b001,
    TIR_TX_EARLY = 3'b010,
    TIR_TX_SEND = 3'b100
  } tir_tx_state_t;
endpackage
`default_nettype wire

// file: rtl/tir_regs.sv
// Register bank of a serial line transceiver: interrupt vectors, masks,
// stack pointers, command flags, FIFO port, command and mode registers.
// Assumes a simple strobe bus and a transceiver core outside that consumes
// and produces FIFO words and reports line events as one-cycle pulses.
// How it works
// - Vector is base register high byte joined with fixed six-bit source.
// - Receiver source field picks full+error, data+error, active; 10 unused.
// - A mask bit at one blocks its interrupt source.
// - Mask bit 3 drives bidirectional pin when pin is an output.
// - Stack pointer register: address pointer high nibble, data low.
// - Transmit empty flag set when empty, cleared by port write.
// - Receive full flag set at three words, cleared by port read.
// - Line active sets on edges, clears after sixteen quiet clocks.
// - Turnaround sets on message end; port write, write one, soft reset clear.
// - Data error flag: coax parity, twinax address 111; read clears.
// - Response, poll/ack, poll flags set on coax commands; read clears.
// - Port write pushes parity, upper bits, byte; read pops receive word.
// - Select-error-codes maps error codes into the port location.
// - Quiesce count select: two quiesce bits at 0, three at 1.
// - Source select: data pin at 0, analog receiver at 1.
// - Advance bit raises transmitter active half a bit early.
// - Odd parity select: even parity at 0, odd at 1.
// - Soft reset bit holds transceiver reset; device reset clears bit.
// - Loopback forces transmitter active low, loops data to receiver.
// - Repeat enable lets receiver stay active while transmitting.
// - Invert bits invert receive and transmit serial data.
// - Three-bit protocol select sets both directions.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "tir_consts.svh"
`default_nettype none
module tir_regs #(
  parameter int RX_DEPTH = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Transceiver core: transmit FIFO
  output logic tx_push_out,
  output logic [11:0] tx_word_out,
  input wire logic tx_fifo_empty_in,
  // Transceiver core: receive FIFO and events
  output logic rx_pop_out,
  input wire logic [10:0] rx_word_in,
  input wire logic [1:0] rx_level_in,
  input wire logic data_ready_in,
  input wire logic rx_active_in,
  input wire logic rx_error_in,
  input wire logic msg_end_in,
  input wire logic parity_err_in,
  input wire logic [2:0] station_addr_in,
  input wire logic cmd_autoresp_in,
  input wire logic cmd_pollack_in,
  input wire logic cmd_poll_in,
  input wire logic [7:0] error_code_reg_in,
  input wire logic tx_busy_in,
  input wire logic half_bit_in,
  // Transceiver core: control
  output logic xcvr_reset_out,
  output tir_pkg::tir_proto_t protocol_select_out,
  output logic three_quiesce_out,
  output logic odd_parity_out,
  output logic rx_enable_out,
  // Serial lines
  input wire logic data_pin_in,
  input wire logic analog_rx_in,
  input wire logic tx_serial_in,
  output logic rx_serial_out,
  output logic tx_data_out,
  output logic tx_active_out,
  // Interrupts
  input wire logic timer_irq_in,
  input wire logic nmi_in,
  input wire logic bidir_irq_pin_in,
  output logic bidir_irq_pin_out,
  output logic bidir_irq_pin_oe_out,
  output logic irq_out,
  output logic [13:0] vector_out
);
  import tir_pkg::*;

  // Register storage
  logic [7:0] interrupt_base;
  logic [7:0] interrupt_control;
  logic [7:0] internal_stack_pointers;
  logic [7:0] transceiver_command;
  logic [7:0] transceiver_mode;
  logic [7:0] timer_high_byte;
  logic [7:0] link_ctrl;

  // Sticky status flags
  logic line_turnaround;
  logic data_error_or_msg_end;
  logic auto_response_flag;
  logic pollack_flag;
  logic poll_flag;

  // Line activity and transmit timing
  logic line_active;
  logic [4:0] quiet_cnt;
  logic rx_prev;
  tir_tx_state_t tx_state;

  // Decodes and interrupt requests
  logic [2:0] src_req;
  logic rx_req;
  logic rx_src;
  logic [7:0] flags;
  logic port_wr;
  logic port_rd;
  logic rx_fifo_full;
  logic coax;
  logic twinax;
  logic soft_reset;
  logic loop;
  logic [5:0] next_vec;
  logic bidir_out_mode;

  // Decoded strobes on the shared port location, and decoded mode and link control bits
  assign port_wr = wr_in && addr_in == `TIR_OFF_RX_TX_PORT;
  assign port_rd = rd_in && addr_in == `TIR_OFF_RX_TX_PORT && !transceiver_command[`TIR_CMD_SEC];
  assign soft_reset = transceiver_mode[`TIR_MODE_SRST];
  assign loop = transceiver_mode[`TIR_MODE_LOOP];
  assign coax = !transceiver_mode[2];
  assign twinax = transceiver_mode[2:1] == 2'b10;
  assign bidir_out_mode = link_ctrl[`TIR_LINK_BIDIR_OUT];

  // Writable registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      interrupt_base <= `TIR_RST_ZERO;
      interrupt_control <= `TIR_RST_ICR;
      internal_stack_pointers <= `TIR_RST_ZERO;
      transceiver_command <= `TIR_RST_ZERO;
      transceiver_mode <= `TIR_RST_ZERO;
      timer_high_byte <= `TIR_RST_ZERO;
      link_ctrl <= `TIR_RST_ZERO;
    end else if (wr_in) begin
      case (addr_in)
        `TIR_OFF_INT_BASE: interrupt_base <= wdata_in;
        `TIR_OFF_INT_CONTROL: interrupt_control <= wdata_in;
        `TIR_OFF_STACK_PTRS: internal_stack_pointers <= wdata_in;
        `TIR_OFF_XCVR_CMD: transceiver_command <= wdata_in;
        `TIR_OFF_XCVR_MODE: transceiver_mode <= wdata_in;
        `TIR_OFF_TIMER_HIGH: timer_high_byte <= wdata_in;
        `TIR_OFF_LINK_CTRL: link_ctrl <= {7'h00, wdata_in[0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_push_out <= 1'b0;
      rx_pop_out <= 1'b0;
      tx_word_out <= 12'h000;
    end else begin
      tx_push_out <= port_wr;
      rx_pop_out <= port_rd;
      // Parity and upper bits as the command register held them
      if (port_wr) begin
        tx_word_out <= {transceiver_command[`TIR_CMD_OWP], transceiver_command[2:0], wdata_in};
      end
    end
  end

  // turnaround flag, set wins
  // Write-one clear sits on the link control location
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      line_turnaround <= 1'b0;
    end else if (msg_end_in) begin
      line_turnaround <= 1'b1;
    end else if (port_wr || soft_reset ||
                 (wr_in && addr_in == `TIR_OFF_LINK_CTRL && wdata_in[`TIR_LINK_EOM])) begin
      line_turnaround <= 1'b0;
    end
  end

  // decoded command flags; set wins over read clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_error_or_msg_end <= 1'b0;
      auto_response_flag <= 1'b0;
      pollack_flag <= 1'b0;
      poll_flag <= 1'b0;
    end else if (soft_reset) begin
      data_error_or_msg_end <= 1'b0;
      auto_response_flag <= 1'b0;
      pollack_flag <= 1'b0;
      poll_flag <= 1'b0;
    end else begin
      if ((coax && parity_err_in) || (twinax && data_ready_in && station_addr_in == 3'h7)) begin
        data_error_or_msg_end <= 1'b1;
      end else if (port_rd) begin
        data_error_or_msg_end <= 1'b0;
      end
      if (coax && data_ready_in && cmd_autoresp_in) begin
        auto_response_flag <= 1'b1;
      end else if (port_rd) begin
        auto_response_flag <= 1'b0;
      end
      if (coax && data_ready_in && cmd_pollack_in) begin
        pollack_flag <= 1'b1;
      end else if (port_rd) begin
        pollack_flag <= 1'b0;
      end
      if (coax && data_ready_in && cmd_poll_in) begin
        poll_flag <= 1'b1;
      end else if (port_rd) begin
        poll_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    rx_src = transceiver_command[`TIR_CMD_SLR] ? analog_rx_in : data_pin_in;
    if (loop) begin
      rx_src = tx_serial_in ^ transceiver_mode[`TIR_MODE_TINV];
    end
    rx_serial_out = rx_src ^ transceiver_mode[`TIR_MODE_RINV];
  end
  assign tx_data_out = tx_serial_in ^ transceiver_mode[`TIR_MODE_TINV];

  // line activity; one clock stands for one transceiver clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_prev <= 1'b0;
      line_active <= 1'b0;
      quiet_cnt <= 5'd0;
    end else begin
      rx_prev <= rx_serial_out;
      if (rx_prev != rx_serial_out) begin
        line_active <= 1'b1;
        quiet_cnt <= 5'd0;
      // Counter runs only while active and idles at zero
      end else if (line_active) begin
        if (quiet_cnt == `TIR_LA_QUIET - 5'd1) begin
          line_active <= 1'b0;
          quiet_cnt <= 5'd0;
        end else begin
          quiet_cnt <= quiet_cnt + 5'd1;
        end
      end
    end
  end

  // transmitter active timing; early only when advanced
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state <= TIR_TX_IDLE;
    end else if (xcvr_reset_out) begin
      tx_state <= TIR_TX_IDLE;
    end else begin
      case (tx_state)
        TIR_TX_IDLE: begin
          if (tx_busy_in) begin
            tx_state <= transceiver_command[`TIR_CMD_ATA] ? TIR_TX_SEND : TIR_TX_EARLY;
          end
        end
        TIR_TX_EARLY: begin
          // Not advanced: active waits for the next half-bit tick
          if (half_bit_in) begin
            tx_state <= TIR_TX_SEND;
          end
        end
        TIR_TX_SEND: begin
          if (!tx_busy_in) begin
            tx_state <= TIR_TX_IDLE;
          end
        end
        default: tx_state <= TIR_TX_IDLE;
      endcase
    end
  end

  assign tx_active_out = !loop && tx_state == TIR_TX_SEND;

  // receiver disabled by transmit unless repeating
  assign rx_enable_out = transceiver_mode[`TIR_MODE_REPEAT_ENABLE] || tx_state == TIR_TX_IDLE;
  // core reset from bit or device reset
  assign xcvr_reset_out = soft_reset || !resetn_in;
  assign protocol_select_out = tir_proto_t'(transceiver_mode[2:0]);
  assign three_quiesce_out = transceiver_command[`TIR_CMD_RLQ];
  assign odd_parity_out = transceiver_command[`TIR_CMD_OWP];

  always_comb begin
    case (interrupt_control[7:6])
      `TIR_RIS_FULL: rx_req = rx_fifo_full || rx_error_in;
      `TIR_RIS_DAV: rx_req = data_ready_in || rx_error_in;
      `TIR_RIS_ACTIVE: rx_req = rx_active_in;
      default: rx_req = 1'b0;
    endcase
  end
  // Raw receiver request; its mask is applied at the vector
  assign src_req[0] = rx_req;
  assign src_req[1] = tx_fifo_empty_in && !interrupt_control[1];
  assign src_req[2] = line_turnaround && !interrupt_control[2];

  // mask bit 3 drives the pin in output mode
  assign bidir_irq_pin_oe_out = bidir_out_mode;
  assign bidir_irq_pin_out = interrupt_control[3];

  always_comb begin
    next_vec = `TIR_VEC_NMI;
    if (nmi_in) begin
      next_vec = `TIR_VEC_NMI;
    end else if (src_req[0] && !interrupt_control[0]) begin
      next_vec = `TIR_VEC_RX;
    end else if (src_req[1]) begin
      next_vec = `TIR_VEC_TX;
    end else if (src_req[2]) begin
      next_vec = `TIR_VEC_LTA;
    end else if (!bidir_out_mode && bidir_irq_pin_in && !interrupt_control[3]) begin
      next_vec = `TIR_VEC_BIDIR;
    end else if (timer_irq_in && !interrupt_control[4]) begin
      next_vec = `TIR_VEC_TIMER;
    end
  end
  // One level request; the vector picks the winner
  assign irq_out = nmi_in || (src_req[0] && !interrupt_control[0]) || src_req[1] || src_req[2] ||
                   (!bidir_out_mode && bidir_irq_pin_in && !interrupt_control[3]) ||
                   (timer_irq_in && !interrupt_control[4]);
  assign vector_out = {interrupt_base, next_vec};

  assign rx_fifo_full = rx_level_in >= `TIR_RX_FULL_LEVEL;
  assign flags = {tx_fifo_empty_in, rx_fifo_full, line_active, line_turnaround,
                  data_error_or_msg_end, auto_response_flag, pollack_flag, poll_flag};

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= `TIR_RST_ZERO;
    end else if (rd_in) begin
      case (addr_in)
        `TIR_OFF_NCF_STATUS: rdata_out <= flags;
        `TIR_OFF_INT_CONTROL: rdata_out <= {interrupt_control[7:6], 1'b0, interrupt_control[4:0]};
        `TIR_OFF_STACK_PTRS: rdata_out <= internal_stack_pointers;
        `TIR_OFF_TIMER_HIGH: rdata_out <= timer_high_byte;
        `TIR_OFF_INT_BASE: rdata_out <= interrupt_base;
        `TIR_OFF_RX_TX_PORT: rdata_out <= transceiver_command[`TIR_CMD_SEC] ? error_code_reg_in : rx_word_in[7:0];
        `TIR_OFF_XCVR_CMD: rdata_out <= transceiver_command;
        `TIR_OFF_XCVR_MODE: rdata_out <= transceiver_mode;
        `TIR_OFF_LINK_CTRL: rdata_out <= link_ctrl;
        `TIR_OFF_VECTOR: rdata_out <= {2'b00, next_vec};
        default: rdata_out <= `TIR_RST_ZERO;
      endcase
    end else begin
      rdata_out <= `TIR_RST_ZERO;
    end
  end
endmodule
`default_nettype wire

// file: tb/tir_regs_chk.sv
// Port checker for the transceiver register bank.
// Assumes it is bound onto tir_regs; shadows follow the bus writes.
`timescale 1ns/1ps
`include "tir_consts.svh"
`default_nettype none
module tir_regs_chk (
  // Clock, reset and register port
  input wire logic clk_in, resetn_in, wr_in, rd_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in, rdata_out, error_code_reg_in,
  // Transceiver core side
  input wire logic tx_push_out, rx_pop_out, xcvr_reset_out, three_quiesce_out, odd_parity_out, rx_enable_out,
  input wire logic [11:0] tx_word_out,
  input wire tir_pkg::tir_proto_t protocol_select_out,
  // Serial lines and interrupts
  input wire logic tx_serial_in, tx_data_out, tx_active_out, bidir_irq_pin_out, bidir_irq_pin_oe_out,
  input wire logic [13:0] vector_out
);
  import tir_pkg::*;
  logic [7:0] base, ictl, cmd, mode;
  // Shadow copies of the written control registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      base <= 8'h00;
      ictl <= `TIR_RST_ICR;
      cmd <= 8'h00;
      mode <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == `TIR_OFF_INT_BASE) base <= wdata_in;
      if (addr_in == `TIR_OFF_INT_CONTROL) ictl <= wdata_in;
      if (addr_in == `TIR_OFF_XCVR_CMD) cmd <= wdata_in;
      if (addr_in == `TIR_OFF_XCVR_MODE) mode <= wdata_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_PUSH: assert property (wr_in && addr_in == `TIR_OFF_RX_TX_PORT |=> tx_push_out)
    else $error("no push after port write");
  AST_WORD: assert property (tx_push_out |-> tx_word_out == {$past(cmd[3:0]), $past(wdata_in)})
    else $error("pushed word wrong");
  AST_POP: assert property (rd_in && addr_in == `TIR_OFF_RX_TX_PORT && !cmd[6] |=> rx_pop_out)
    else $error("no pop after port read");
  AST_ERRMAP: assert property (rd_in && addr_in == `TIR_OFF_RX_TX_PORT && cmd[6]
    |=> !rx_pop_out && rdata_out == $past(error_code_reg_in))
    else $error("error codes not mapped");
  AST_BASE: assert property (vector_out[13:6] == base)
    else $error("vector high byte wrong");
  AST_BIDIR: assert property (bidir_irq_pin_oe_out |-> bidir_irq_pin_out == ictl[3])
    else $error("bidir pin level wrong");
  AST_SRST: assert property (xcvr_reset_out == mode[7])
    else $error("transceiver reset wrong");
  AST_PROTO: assert property (protocol_select_out == mode[2:0])
    else $error("protocol select wrong");
  AST_LOOP: assert property (mode[6] |-> !tx_active_out)
    else $error("active in loopback");
  AST_TINV: assert property (!mode[6] |-> tx_data_out == (tx_serial_in ^ mode[3]))
    else $error("transmit data polarity wrong");
  AST_CFG: assert property (three_quiesce_out == cmd[7] && odd_parity_out == cmd[3])
    else $error("quiesce or parity select wrong");
  AST_REPEAT_ENABLE: assert property (mode[5] && !mode[7] |-> rx_enable_out)
    else $error("receiver off with repeat");
  // Main scenarios
  COV_PUSH: cover property (tx_push_out);
  COV_ERRMAP: cover property (rd_in && addr_in == `TIR_OFF_RX_TX_PORT && cmd[6]);
  COV_LOOP: cover property (mode[6] && tx_serial_in);
  COV_BIDIR: cover property (bidir_irq_pin_oe_out && bidir_irq_pin_out);
endmodule
bind tir_regs tir_regs_chk u_chk (.clk_in, .resetn_in, .wr_in, .rd_in, .addr_in, .wdata_in, .rdata_out,
  .error_code_reg_in, .tx_push_out, .rx_pop_out, .xcvr_reset_out, .three_quiesce_out, .odd_parity_out,
  .rx_enable_out, .tx_word_out, .protocol_select_out, .tx_serial_in, .tx_data_out, .tx_active_out,
  .bidir_irq_pin_out, .bidir_irq_pin_oe_out, .vector_out);
`default_nettype wire

// file: tb/tir_xcvr_model.sv
// Behavioural transceiver core facing the register bank.
// Assumes one clock; the bench hands in received words.
`timescale 1ns/1ps
`default_nettype none
module tir_xcvr_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bank side
  input wire logic tx_push_in,
  input wire logic rx_pop_in,
  // Bench side
  input wire logic put_in,
  input wire logic [10:0] put_word_in,
  // Core outputs
  output logic tx_fifo_empty_out,
  output logic [10:0] rx_word_out,
  output logic [1:0] rx_level_out,
  output logic data_ready_out,
  output logic tx_busy_out,
  output logic tx_serial_out
);
  logic [10:0] rxq [$];
  logic [10:0] last;
  int tx_cnt;
  // Queues; an empty FIFO shows the inverse of the last word, not a stale copy
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxq.delete();
      tx_cnt = 0;
      last = 11'h000;
    end else begin
      if (rx_pop_in && rxq.size() > 0) last = rxq.pop_front();
      if (put_in && rxq.size() < 3) rxq.push_back(put_word_in);
      if (tx_push_in) tx_cnt = 20;
      else if (tx_cnt > 0) tx_cnt = tx_cnt - 1;
    end
    rx_level_out <= 2'(rxq.size());
    data_ready_out <= rxq.size() > 0;
    rx_word_out <= (rxq.size() > 0) ? rxq[0] : ~last;
    tx_busy_out <= tx_cnt > 0;
    tx_fifo_empty_out <= tx_cnt == 0;
    tx_serial_out <= tx_cnt[1];
  end
endmodule
`default_nettype wire

// file: tb/tir_regs_tb_top.sv
// Self-checking bench for the transceiver register bank.
// Assumes tir_xcvr_model as core and the bound port checker.
`timescale 1ns/1ps
`include "tir_consts.svh"
`default_nettype none
module tir_regs_tb_top;
  import tir_pkg::*;
  localparam logic [4:0] a_flags = `TIR_OFF_NCF_STATUS, a_port = `TIR_OFF_RX_TX_PORT, a_cmd = `TIR_OFF_XCVR_CMD;
  localparam logic [4:0] a_mode = `TIR_OFF_XCVR_MODE, a_ctl = `TIR_OFF_INT_CONTROL, a_link = `TIR_OFF_LINK_CTRL;
  // Design inputs
  logic clk_in = 1'h0, resetn_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0, half_bit_in = 1'h0;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00, error_code_reg_in = 8'h00;
  logic [2:0] station_addr_in = 3'h0;
  logic msg_end_in = 1'h0, parity_err_in = 1'h0, cmd_autoresp_in = 1'h0, cmd_pollack_in = 1'h0;
  logic cmd_poll_in = 1'h0, rx_active_in = 1'h0, rx_error_in = 1'h0, data_pin_in = 1'h0, analog_rx_in = 1'h0;
  logic timer_irq_in = 1'h0, nmi_in = 1'h0, bidir_irq_pin_in = 1'h0;
  logic tx_fifo_empty_in, data_ready_in, tx_busy_in, tx_serial_in;
  logic [10:0] rx_word_in;
  logic [1:0] rx_level_in;
  // Design outputs
  logic [7:0] rdata_out;
  logic [11:0] tx_word_out;
  logic [13:0] vector_out;
  tir_proto_t protocol_select_out;
  logic tx_push_out, rx_pop_out, xcvr_reset_out, three_quiesce_out, odd_parity_out, rx_enable_out;
  logic rx_serial_out, tx_data_out, tx_active_out, bidir_irq_pin_out, bidir_irq_pin_oe_out, irq_out;
  // Bench state
  logic put = 1'h0;
  logic [10:0] put_word = 11'h000;
  logic [10:0] words [3];
  logic [7:0] d, b;
  logic [4:0] offs [5] = '{`TIR_OFF_INT_BASE, `TIR_OFF_STACK_PTRS, `TIR_OFF_TIMER_HIGH, a_cmd, a_mode};
  logic [2:0] hb = 3'h0;
  int n_errors = 0, samples_checked = 0, seed = 72, i;
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  // Half-bit tick every eight clocks
  always @(posedge clk_in) begin
    hb <= hb + 3'h1;
    half_bit_in <= hb == 3'h7;
  end
  tir_regs #(.RX_DEPTH(3)) DUT (.*);
  tir_xcvr_model u_model (.clk_in, .resetn_in, .tx_push_in(tx_push_out), .rx_pop_in(rx_pop_out), .put_in(put),
    .put_word_in(put_word), .tx_fifo_empty_out(tx_fifo_empty_in), .rx_word_out(rx_word_in),
    .rx_level_out(rx_level_in), .data_ready_out(data_ready_in), .tx_busy_out(tx_busy_in), .tx_serial_out(tx_serial_in));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'h1;
    @(posedge clk_in);
    wr_in <= 1'h0;
    #1;
  endtask
  // Read data are taken in the one cycle they stand
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] m, e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 d = rdata_out;
    chk(nm, {8'h00, d & m}, {8'h00, e & m});
  endtask
  task automatic put_rx(input logic [10:0] w);
    @(posedge clk_in);
    put <= 1'h1;
    put_word <= w;
    @(posedge clk_in);
    put <= 1'h0;
  endtask
  // One-cycle event pulse: message end, parity, three coax commands
  task automatic pulse(input logic [4:0] f);
    @(posedge clk_in);
    {msg_end_in, parity_err_in, cmd_autoresp_in, cmd_pollack_in, cmd_poll_in} <= f;
    @(posedge clk_in);
    {msg_end_in, parity_err_in, cmd_autoresp_in, cmd_pollack_in, cmd_poll_in} <= 5'h00;
  endtask
  task automatic drain;
    for (i = 0; i < 100 && tx_fifo_empty_in !== 1'h1; i++) @(posedge clk_in);
    if (tx_fifo_empty_in !== 1'h1) begin
      n_errors++;
      report_and_stop;
    end
  endtask
  function automatic logic exp_rx_irq(input logic [1:0] src, input logic err, act);
    return (src == `TIR_RIS_FULL || src == `TIR_RIS_DAV) ? err : (src == `TIR_RIS_ACTIVE && act);
  endfunction
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'h1;
    // Reset values, then writes to unmapped and read-only places
    rchk("ctl_rst", a_ctl, 8'hdf, `TIR_RST_ICR);
    foreach (offs[k]) rchk("reg_rst", offs[k], 8'hff, 8'h00);
    wr(5'h05, 8'h5a);
    wr(a_flags, 8'h7f);
    rchk("unmapped", 5'h05, 8'hff, 8'h00);
    rchk("flags_rst", a_flags, 8'hff, 8'h80);
    // Random readback while the serial inputs wiggle
    for (i = 0; i < 30; i++) begin
      d = 8'($random(seed));
      wr(offs[i % 5], d);
      data_pin_in <= d[0];
      analog_rx_in <= d[1];
      rchk("rw", offs[i % 5], 8'hff, d);
    end
    wr(a_mode, 8'h00);
    wr(a_cmd, 8'h00);
    data_pin_in <= 1'h0;
    analog_rx_in <= 1'h0;
    repeat (24) @(posedge clk_in);
    $display("test registers done");
    // Turnaround flag set by message end, cleared three ways
    for (int k = 0; k < 3; k++) begin
      pulse(5'h10);
      rchk("turn_set", a_flags, 8'h10, 8'h10);
      case (k)
        0: wr(a_link, 8'h02);
        1: wr(a_port, 8'h3c);
        default: begin
          wr(a_mode, 8'h80);
          wr(a_mode, 8'h00);
        end
      endcase
      rchk("turn_clr", a_flags, 8'h10, 8'h00);
      drain;
    end
    for (int k = 0; k < 2; k++) begin
      wr(a_cmd, k ? 8'h1d : 8'h0d);
      wr(a_port, 8'ha5);
      rchk("txe_busy", a_flags, 8'h80, 8'h00);
      chk("tx_adv", tx_active_out, k[0]);
      drain;
      repeat (2) @(posedge clk_in);
      rchk("txe_idle", a_flags, 8'h80, 8'h80);
    end
    wr(a_cmd, 8'h00);
    $display("test transmit done");
    // Three words fill the FIFO; coax flags set with data ready
    for (int k = 0; k < 3; k++) begin
      words[k] = 11'($random(seed));
      put_rx(words[k]);
    end
    pulse(5'h0f);
    rchk("rx_full", a_flags, 8'h4f, 8'h4f);
    for (int k = 0; k < 3; k++) begin
      rchk("rx_pop", a_port, 8'hff, words[k][7:0]);
      rchk("rx_clr", a_flags, 8'h4f, 8'h00);
    end
    wr(a_mode, {5'h00, TIR_PROTO_TWINAX});
    station_addr_in <= 3'h7;
    put_rx(11'h123);
    @(posedge clk_in);
    station_addr_in <= 3'h0;
    rchk("err_set", a_flags, 8'h08, 8'h08);
    rchk("err_pop", a_port, 8'hff, 8'h23);
    rchk("err_clr", a_flags, 8'h08, 8'h00);
    wr(a_mode, 8'h00);
    // Error codes take the port place; the FIFO word stays
    error_code_reg_in <= 8'($random(seed));
    wr(a_cmd, 8'h40);
    put_rx(11'h7e1);
    rchk("errmap", a_port, 8'hff, error_code_reg_in);
    wr(a_cmd, 8'h00);
    rchk("errmap_off", a_port, 8'hff, 8'he1);
    $display("test receive done");
    // Line activity follows only the selected receiver input
    for (int k = 0; k < 2; k++) begin
      wr(a_cmd, k ? 8'h20 : 8'h00);
      repeat (24) @(posedge clk_in);
      data_pin_in <= ~data_pin_in;
      rchk("act_data", a_flags, 8'h20, k ? 8'h00 : 8'h20);
      analog_rx_in <= ~analog_rx_in;
      rchk("act_analog", a_flags, 8'h20, 8'h20);
      repeat (20) @(posedge clk_in);
      rchk("act_quiet", a_flags, 8'h20, 8'h00);
    end
    wr(a_cmd, 8'h00);
    $display("test line done");
    // Vector forming, masks, receiver source choice, bidir pin
    b = 8'($random(seed));
    wr(`TIR_OFF_INT_BASE, b);
    timer_irq_in <= 1'h1;
    wr(a_ctl, 8'h0f);
    rchk("ctl_rw", a_ctl, 8'hdf, 8'h0f);
    chk("irq_timer", irq_out, 1'h1);
    chk("vec_timer", vector_out, {b, `TIR_VEC_TIMER});
    wr(a_ctl, 8'h1f);
    chk("irq_masked", irq_out, 1'h0);
    timer_irq_in <= 1'h0;
    for (int r = 0; r < 4; r++) begin
      wr(a_ctl, {r[1:0], 6'h1e});
      rx_error_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      #1;
      chk("rsrc_err", irq_out, exp_rx_irq(r[1:0], 1'h1, 1'h0));
      if (r == 0) chk("vec_rx", vector_out[5:0], `TIR_VEC_RX);
      rx_error_in <= 1'h0;
      rx_active_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      #1;
      chk("rsrc_act", irq_out, exp_rx_irq(r[1:0], 1'h0, 1'h1));
      rx_active_in <= 1'h0;
    end
    wr(a_link, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(a_ctl, k ? 8'h17 : 8'h1f);
      chk("bidir_pin", {bidir_irq_pin_oe_out, bidir_irq_pin_out}, {1'h1, ~k[0]});
    end
    wr(a_link, 8'h00);
    nmi_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    chk("vec_nmi", vector_out, {b, `TIR_VEC_NMI});
    nmi_in <= 1'h0;
    $display("test interrupts done");
    report_and_stop;
  end
endmodule
`default_nettype wire
